// *** hdl/cmpp_pkg.sv ***
package cmpp_pkg;
    localparam int CLK_MHZ = 100;
    localparam int CMD_BITS = 6;
    localparam int PAY_BITS = 16;
    localparam logic [3:0] CMD_LAST = 4'h5;
    localparam logic [3:0] PAY_LAST = 4'hF;
    localparam logic [15:0] A_UID0 = 16'h8000;
    localparam logic [15:0] A_PROG0 = 16'h0000;
    localparam logic [13:0] A_UID_HI = 14'h2000;
    localparam logic [15:0] A_DEVID = 16'h8006;
    localparam logic [15:0] A_CFG1 = 16'h8007;
    localparam logic [15:0] A_CFG2 = 16'h8008;
    localparam logic [15:0] A_CAL1 = 16'h8009;
    localparam logic [15:0] A_CAL2 = 16'h800A;
    localparam logic [13:0] ONES = 14'h3FFF;
    localparam logic [13:0] ZERO14 = 14'h0000;
    localparam logic [13:0] CFG1_IMPL = 14'h3EFF;
    localparam logic [13:0] CFG2_IMPL_STD = 14'h3E13;
    localparam logic [13:0] CFG2_IMPL_LV = 14'h3E03;
    localparam int PART_LSB = 5;
    localparam int CP_BIT = 7;
    localparam int VCAP_BIT = 4;
    localparam int T_ERAB_US = 5000;
    localparam int T_ERAR_US = 2500;
    localparam int T_PINT_US = 2500;
    localparam int ERAB_CYC = T_ERAB_US * CLK_MHZ;
    localparam int ERAR_CYC = T_ERAR_US * CLK_MHZ;
    localparam int PINT_CYC = T_PINT_US * CLK_MHZ;
    localparam int T_DLY_NS = 1000;

    typedef enum logic [4:0] {
        C_LDCFG = 5'h00, C_LDPM = 5'h02, C_RDPM = 5'h04, C_INCA = 5'h06,
        C_RSTA = 5'h16, C_PINT = 5'h08, C_PEXT = 5'h18, C_PEND = 5'h0A,
        C_BULK = 5'h09, C_ROW = 5'h11
    } cmpp_cmd_e;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000, OP_READ = 3'b001, OP_INT = 3'b010, OP_EXTB = 3'b011,
        OP_EXTE = 3'b100, OP_BULK = 3'b101, OP_ROW = 3'b110
    } cmpp_op_e;

    typedef enum logic [1:0] {
        L_CMD = 2'b00, L_LOAD = 2'b01, L_READ = 2'b10
    } cmpp_link_e;

    typedef struct packed {
        cmpp_op_e op;
        logic [15:0] addr;
        logic [13:0] data;
    } cmpp_req_s;
endpackage

// *** hdl/cmpp_core.sv ***
module cmpp_core
    import cmpp_pkg::*;
#(
    parameter int PMEM_AW = 14,
    parameter int ROW_WORDS = 32,
    parameter bit LOW_VOLT = 1'b0,
    parameter logic [8:0] PART_CODE = 9'h0A5, // arbitrary value
    parameter logic [4:0] REV_CODE = 5'h01, // arbitrary value
    parameter logic [13:0] CAL1_INIT = 14'h2000,
    parameter logic [13:0] CAL2_INIT = 14'h2000,
    parameter int ERAB_CYCLES = ERAB_CYC,
    parameter int ERAR_CYCLES = ERAR_CYC,
    parameter int PINT_CYCLES = PINT_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic pclk,
    input wire logic prog_mode,
    input wire logic pdat_i,
    output logic pdat_o,
    output logic pdat_oe,
    output logic busy,
    output logic code_protect,
    output logic [1:0] self_write_lock_field,
    output logic regulator_cap_enable
);
    localparam int RB = $clog2(ROW_WORDS);
    localparam logic [13:0] CFG2_IMPL = LOW_VOLT ? CFG2_IMPL_LV : CFG2_IMPL_STD;
    localparam logic [13:0] ID_WORD = {PART_CODE, REV_CODE};

    // link side, on the programmer's clock
    logic [1:0] mode_sync;
    logic in_mode;
    cmpp_link_e state;
    logic [3:0] cnt;
    logic [15:0] sr;
    logic [15:0] next_sr;
    logic [15:0] addr;
    logic [13:0] latch;
    logic [13:0] out_word;
    cmpp_req_s req;
    logic req_tgl;
    logic cmd_end;
    logic [4:0] code;

    // core side
    logic [2:0] tgl_sync;
    logic new_req;
    logic [13:0] rd_word;
    logic [13:0] pmem [2**PMEM_AW];
    logic [3:0][13:0] uid;
    logic [13:0] cfg1;
    logic [13:0] cfg2;
    logic [1:0][13:0] cal;
    logic prot;
    logic ext_on;
    logic [22:0] tmr;
    logic swp_on;
    logic [PMEM_AW-1:0] swp_cnt;
    logic [PMEM_AW-1:0] swp_lim;
    logic [PMEM_AW-1:0] idx;
    logic st_int;
    logic st_bulk;
    logic st_row;
    logic wr_go;

    assign in_mode = mode_sync[1];
    assign next_sr = {pdat_i, sr[15:1]};
    assign cmd_end = in_mode && state == L_CMD && cnt == CMD_LAST;
    assign code = next_sr[14:10]; // top command bit dropped

    always_ff @(posedge pclk or posedge rst) begin
        if (rst) begin
            mode_sync <= 2'h0;
        end else begin
            mode_sync <= {mode_sync[0], prog_mode};
        end
    end

    // bits arrive lsb first; payload framing counted here
    always_ff @(posedge pclk or posedge rst) begin
        if (rst) begin
            state <= L_CMD;
            cnt <= 4'h0;
            sr <= 16'h0000;
        end else begin
            sr <= next_sr;
            if (!in_mode) begin
                state <= L_CMD;
                cnt <= 4'h0;
            end else begin
                case (state)
                    L_CMD: begin
                        if (cnt == CMD_LAST) begin
                            cnt <= 4'h0;
                            if (code == C_LDCFG || code == C_LDPM) begin
                                state <= L_LOAD;
                            end else if (code == C_RDPM) begin
                                state <= L_READ;
                            end
                        end else begin
                            cnt <= cnt + 4'h1;
                        end
                    end
                    L_LOAD, L_READ: begin
                        if (cnt == PAY_LAST) begin
                            cnt <= 4'h0;
                            state <= L_CMD;
                        end else begin
                            cnt <= cnt + 4'h1;
                        end
                    end
                    default: state <= L_CMD;
                endcase
            end
        end
    end

    // address only drops back to zero by the reset command or mode exit
    always_ff @(posedge pclk or posedge rst) begin
        if (rst) begin
            addr <= A_PROG0;
            latch <= ONES;
        end else begin
            if (!in_mode) begin
                addr <= A_PROG0;
            end else if (cmd_end) begin
                case (code)
                    C_LDCFG: addr <= A_UID0;
                    C_INCA: addr <= addr + 16'h0001;
                    C_RSTA: addr <= A_PROG0;
                    default: addr <= addr;
                endcase
            end
            if (in_mode && state == L_LOAD && cnt == PAY_LAST) begin
                latch <= next_sr[14:1]; // start and stop bits dropped
            end
        end
    end

    // request words stay put until the next command, long after the core took them
    always_ff @(posedge pclk or posedge rst) begin
        if (rst) begin
            req <= '{op: OP_NONE, addr: A_PROG0, data: ONES};
            req_tgl <= 1'b0;
        end else if (cmd_end) begin
            req.addr <= addr;
            req.data <= latch;
            req_tgl <= req_tgl ^ (code inside {C_RDPM, C_PINT, C_PEXT, C_PEND, C_BULK, C_ROW});
            case (code)
                C_RDPM: req.op <= OP_READ;
                C_PINT: req.op <= OP_INT;
                C_PEXT: req.op <= OP_EXTB;
                C_PEND: req.op <= OP_EXTE;
                C_BULK: req.op <= OP_BULK;
                C_ROW: req.op <= OP_ROW;
                default: req.op <= req.op;
            endcase
        end
    end

    // read word is taken at the first payload clock; the command gap lets the core settle it
    always_ff @(posedge pclk or posedge rst) begin
        if (rst) begin
            pdat_o <= 1'b0;
            pdat_oe <= 1'b0;
            out_word <= ONES;
        end else if (!in_mode) begin
            pdat_oe <= 1'b0;
            pdat_o <= 1'b0;
        end else if (cmd_end && code == C_RDPM) begin
            pdat_oe <= 1'b1;
            pdat_o <= 1'b0;
        end else if (state == L_READ) begin
            if (cnt == 4'h0) begin
                out_word <= rd_word;
                pdat_o <= rd_word[0];
            end else if (cnt < 4'hE) begin
                pdat_o <= out_word[cnt];
            end else if (cnt == 4'hE) begin
                pdat_o <= 1'b0;
            end else begin
                pdat_oe <= 1'b0;
            end
        end
    end

    // toggle crossing into the core clock
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tgl_sync <= 3'h0;
        end else begin
            tgl_sync <= {tgl_sync[1:0], req_tgl};
        end
    end

    assign new_req = tgl_sync[2] ^ tgl_sync[1];
    assign idx = req.addr[PMEM_AW-1:0];
    assign prot = !cfg1[CP_BIT];
    assign st_int = new_req && !busy && req.op == OP_INT;
    assign st_bulk = new_req && !busy && req.op == OP_BULK;
    assign st_row = new_req && !busy && req.op == OP_ROW && !prot;
    assign wr_go = st_int || (new_req && req.op == OP_EXTE && ext_on);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_word <= ONES;
        end else if (new_req && req.op == OP_READ) begin
            if (!req.addr[15]) begin
                rd_word <= prot ? ZERO14 : pmem[idx];
            end else if (req.addr[15:2] == A_UID_HI) begin
                rd_word <= uid[req.addr[1:0]];
            end else begin
                case (req.addr)
                    A_DEVID: rd_word <= ID_WORD;
                    A_CFG1: rd_word <= cfg1;
                    A_CFG2: rd_word <= cfg2;
                    A_CAL1: rd_word <= cal[0];
                    A_CAL2: rd_word <= cal[1];
                    default: rd_word <= ONES;
                endcase
            end
        end
    end

    // config space is the same on every variant except that LOW_VOLT leaves cfg2 bit VCAP_BIT unimplemented (reads one)
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            uid <= {4{ONES}};
            cfg1 <= ONES;
            cfg2 <= ONES;
            cal <= {CAL2_INIT, CAL1_INIT};
        end else if (st_bulk) begin
            uid <= {4{ONES}}; // calibration and identity untouched
            cfg1 <= ONES;
            cfg2 <= ONES;
        end else if (wr_go && req.addr[15] && req.op == OP_INT) begin
            if (req.addr[15:2] == A_UID_HI) begin
                uid[req.addr[1:0]] <= req.data;
            end else begin
                case (req.addr)
                    A_CFG1: cfg1 <= req.data | ~CFG1_IMPL;
                    A_CFG2: cfg2 <= req.data | ~CFG2_IMPL;
                    A_CAL1: cal[0] <= req.data;
                    A_CAL2: cal[1] <= req.data;
                    default: cal <= cal;
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (swp_on) begin
            pmem[swp_cnt] <= ONES;
        end else if (wr_go && !req.addr[15] && !prot) begin
            pmem[idx] <= req.data;
        end
    end

    // erase walks one word a clock, hidden inside the timed cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            swp_on <= 1'b0;
            swp_cnt <= '0;
            swp_lim <= '0;
        end else if (st_bulk) begin
            swp_on <= 1'b1;
            swp_cnt <= '0;
            swp_lim <= '1;
        end else if (st_row) begin
            swp_on <= 1'b1;
            swp_cnt <= {idx[PMEM_AW-1:RB], RB'(0)};
            swp_lim <= {idx[PMEM_AW-1:RB], {RB{1'b1}}};
        end else if (swp_on) begin
            swp_on <= swp_cnt != swp_lim;
            swp_cnt <= swp_cnt + PMEM_AW'(1);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tmr <= 23'h000000;
            ext_on <= 1'b0;
            busy <= 1'b0;
        end else begin
            if (st_int) begin
                tmr <= 23'(PINT_CYCLES);
            end else if (st_bulk) begin
                tmr <= 23'(ERAB_CYCLES);
            end else if (st_row) begin
                tmr <= 23'(ERAR_CYCLES);
            end else if (tmr != 23'h000000) begin
                tmr <= tmr - 23'h000001;
            end
            if (new_req && req.op == OP_EXTB && !busy) begin
                ext_on <= 1'b1;
            end else if (new_req && req.op == OP_EXTE) begin
                ext_on <= 1'b0;
            end
            busy <= st_int || st_bulk || st_row || tmr > 23'h000001 || swp_on;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            code_protect <= 1'b0;
            self_write_lock_field <= 2'h3;
            regulator_cap_enable <= 1'b0;
        end else begin
            code_protect <= prot;
            self_write_lock_field <= cfg2[1:0];
            regulator_cap_enable <= !LOW_VOLT && !cfg2[VCAP_BIT];
        end
    end

    sequence s_drive8;
        pdat_oe [*8];
    endsequence

    a_payload_len: assert property (@(posedge pclk) disable iff (rst)
        $rose(pdat_oe) |-> s_drive8 ##1 s_drive8 ##1 !pdat_oe)
        else $error("read payload not 16 clocks");
    a_start_bit: assert property (@(posedge pclk) disable iff (rst)
        cmd_end && code == C_RDPM |=> pdat_oe && !pdat_o)
        else $error("start bit not zero");
    a_cfg_addr: assert property (@(posedge pclk) disable iff (rst)
        cmd_end && code == C_LDCFG |=> addr == A_UID0)
        else $error("load config address wrong");
    a_addr_zero: assert property (@(posedge pclk) disable iff (rst)
        cmd_end && code == C_RSTA |=> addr == A_PROG0)
        else $error("reset address failed");
    a_id_read: assert property (@(posedge mclk) disable iff (rst)
        new_req && req.op == OP_READ && req.addr == A_DEVID |=> rd_word == ID_WORD)
        else $error("identity word wrong");
    a_uid_read: assert property (@(posedge mclk) disable iff (rst)
        new_req && req.op == OP_READ && req.addr[15:2] == A_UID_HI |=> rd_word == uid[$past(req.addr[1:0])])
        else $error("user id read wrong");
    a_prot_zero: assert property (@(posedge mclk) disable iff (rst)
        new_req && req.op == OP_READ && !req.addr[15] && prot |=> rd_word == ZERO14)
        else $error("protected read not zero");
    a_cal_hold: assert property (@(posedge mclk) disable iff (rst)
        swp_on || st_bulk |=> $stable(cal))
        else $error("erase changed calibration");
    a_ext_cfg: assert property (@(posedge mclk) disable iff (rst)
        new_req && req.op == OP_EXTE && req.addr[15] |=> $stable({uid, cfg1, cfg2, cal}))
        else $error("external write changed config");
    a_unimpl_one: assert property (@(posedge mclk) disable iff (rst)
        ((cfg1 | CFG1_IMPL) == ONES) && ((cfg2 | CFG2_IMPL) == ONES))
        else $error("unimplemented bit not one");
    a_bulk_busy: assert property (@(posedge mclk) disable iff (rst)
        st_bulk |=> busy [*8])
        else $error("bulk erase not timed");
endmodule

// *** bench/cmpp_prog_model.sv ***
module cmpp_prog_model
    import cmpp_pkg::*;
#(
    parameter int HALF_NS = 3,
    parameter int GAP_NS = T_DLY_NS
) (
    output logic pclk,
    output logic prog_mode,
    output wire logic pdat_i,
    input wire logic pdat_o,
    input wire logic pdat_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic drv;
    // resolved pin level: the device wins while it drives
    assign pdat_i = pdat_oe ? pdat_o : drv;
    initial begin
        pclk = 1'b0;
        prog_mode = 1'b0;
        drv = 1'b1;
    end
    // data is set up while the clock is low, clock stands still between frames
    task automatic tick(input logic b);
        drv = b;
        #(HALF_NS) pclk = 1'b1;
        #(HALF_NS) pclk = 1'b0;
    endtask
    // released line shows the inverse of the last bit so a stale value cannot pass
    task automatic gap();
        drv = ~drv;
        #(GAP_NS);
    endtask
    task automatic enter();
        prog_mode = 1'b1;
        repeat (2) tick(1'b0);
        gap();
    endtask
    task automatic cmd(input logic [5:0] c);
        for (int i = 0; i < CMD_BITS; i++) begin
            tick(c[i]);
        end
        gap();
    endtask
    task automatic load(input logic [13:0] w);
        tick(1'b0);
        for (int i = 0; i < 14; i++) begin
            tick(w[i]);
        end
        tick(1'b0);
        gap();
    endtask
    // frm = {oe held over edges 0..14, stop bit, oe after edge 15}
    task automatic read(output logic [13:0] w, output logic [2:0] frm);
        frm = 3'b100;
        for (int i = 0; i < PAY_BITS; i++) begin
            drv = ~drv;
            #(HALF_NS) pclk = 1'b1;
            #1;
            if (i < 15 && pdat_oe !== 1'b1) frm[2] = 1'b0;
            if (i < 14) w[i] = pdat_o;
            if (i == 14) frm[1] = pdat_o;
            if (i == 15) frm[0] = pdat_oe;
            #(HALF_NS - 1) pclk = 1'b0;
        end
        gap();
    endtask
endmodule

// *** bench/cmpp_tb_top.sv ***
module cmpp_tb_top import cmpp_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    // part, revision and second calibration word keep the core's defaults to limit overrides
    localparam logic [8:0] PART = 9'h0A5; // arbitrary value
    localparam logic [4:0] REV = 5'h01; // arbitrary value
    localparam logic [13:0] CAL1 = 14'h1234;
    localparam logic [13:0] CAL2 = 14'h2000;
    logic mclk, rst, pclk, prog_mode, pdat_i, pdat_o, pdat_oe, busy, code_protect, regulator_cap_enable;
    logic [1:0] self_write_lock_field;
    int err_count, n_tests;

    cmpp_core #(.PMEM_AW(8), .CAL1_INIT(CAL1),
        .ERAB_CYCLES(300), .ERAR_CYCLES(64), .PINT_CYCLES(64)) dut_u (
        .mclk(mclk), .rst(rst), .pclk(pclk), .prog_mode(prog_mode), .pdat_i(pdat_i), .pdat_o(pdat_o),
        .pdat_oe(pdat_oe), .busy(busy), .code_protect(code_protect),
        .self_write_lock_field(self_write_lock_field), .regulator_cap_enable(regulator_cap_enable));
    cmpp_prog_model pm_u (.pclk(pclk), .prog_mode(prog_mode), .pdat_i(pdat_i), .pdat_o(pdat_o),
        .pdat_oe(pdat_oe));

    initial begin
        mclk = 1'b0;
    end
    always #5 mclk = ~mclk;

    task automatic conclude();
        if (err_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [13:0] exp, input logic [13:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic settle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 5000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 5000) begin
            err_count++;
            $display("BAD busy expected 0 seen %b", busy);
            conclude();
        end
    endtask
    task automatic rd(input logic [5:0] c, input string nm, input logic [13:0] exp);
        logic [13:0] w;
        logic [2:0] f;
        pm_u.cmd(c);
        pm_u.read(w, f);
        chk(nm, exp, w);
        chk({nm, "_frame"}, 14'h0004, {11'h000, f});
    endtask
    task automatic run(input logic [5:0] c);
        pm_u.cmd(c);
        settle();
    endtask
    task automatic wr(input logic [13:0] d);
        pm_u.cmd(6'h02);
        pm_u.load(d);
        run(6'h08);
    endtask
    task automatic cfg_at(input int n);
        pm_u.cmd(6'h00);
        pm_u.load(14'h0000);
        repeat (n) pm_u.cmd(6'h06);
    endtask

    initial begin
        rst = 1'b1;
        err_count = 0;
        n_tests = 0;
        repeat (3) @(negedge mclk);
        chk("lock_in_reset", 14'h0003, {12'h000, self_write_lock_field});
        chk("protect_in_reset", 14'h0000, {13'h0000, code_protect});
        rst = 1'b0;
        repeat (3) @(negedge mclk);
        pm_u.enter();
        run(6'h09);
        rd(6'h04, "pm0_blank", ONES);
        wr(14'h1555);
        rd(6'h24, "pm0_msb_cmd", 14'h1555);
        pm_u.cmd(6'h06);
        pm_u.cmd(6'h02);
        pm_u.load(14'h0333);
        run(6'h18);
        run(6'h0A);
        rd(6'h04, "pm1_ext", 14'h0333);
        run(6'h11);
        pm_u.cmd(6'h16);
        rd(6'h04, "pm0_row_erased", ONES);
        wr(14'h1555);
        pm_u.cmd(6'h00);
        pm_u.load(14'h0AAA);
        rd(6'h04, "uid0_blank", ONES);
        run(6'h08);
        rd(6'h04, "uid0", 14'h0AAA);
        for (int i = 1; i < 4; i++) begin
            pm_u.cmd(6'h06);
            wr(14'h1000 + 14'(i));
            rd(6'h04, "uid", 14'h1000 + 14'(i));
        end
        repeat (3) pm_u.cmd(6'h06);
        rd(6'h04, "part_identity", {PART, REV});
        wr(14'h0000);
        rd(6'h04, "part_identity_ro", {PART, REV});
        pm_u.cmd(6'h06);
        rd(6'h04, "cfg1_blank", ONES);
        pm_u.cmd(6'h06);
        rd(6'h04, "cfg2_blank", ONES);
        chk("lock_blank", 14'h0003, {12'h000, self_write_lock_field});
        chk("cap_blank", 14'h0000, {13'h0000, regulator_cap_enable});
        pm_u.cmd(6'h06);
        rd(6'h04, "cal1", CAL1);
        pm_u.cmd(6'h06);
        rd(6'h04, "cal2", CAL2);
        cfg_at(7);
        pm_u.cmd(6'h02);
        pm_u.load(14'h0000);
        run(6'h18);
        run(6'h0A);
        rd(6'h04, "cfg1_ext_ignored", ONES);
        wr(14'h3F7F);
        rd(6'h04, "cfg1_protect", 14'h3F7F);
        chk("protect_on", 14'h0001, {13'h0000, code_protect});
        pm_u.cmd(6'h16);
        rd(6'h04, "pm0_protected", ZERO14);
        cfg_at(0);
        rd(6'h04, "uid0_protected", 14'h0AAA);
        for (int c = 0; c < 4; c++) begin
            run(6'h09);
            cfg_at(0);
            rd(6'h04, "uid0_erased", ONES);
            repeat (8) pm_u.cmd(6'h06);
            wr(14'(c));
            rd(6'h04, "cfg2_unimpl_ones", 14'h01EC | 14'(c));
            chk("lock_field", 14'(c), {12'h000, self_write_lock_field});
            chk("cap_enable", 14'h0001, {13'h0000, regulator_cap_enable});
            chk("protect_cleared", 14'h0000, {13'h0000, code_protect});
            pm_u.cmd(6'h06);
            rd(6'h04, "cal1_kept", CAL1);
        end
        conclude();
    end
endmodule
